// ==== isr_readout.sv ====
// image sensor readout control: registers, timing and pixel output
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "isr_params.svh"
module isr_readout (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// sensor control pins
	input wire logic chip_reset_low_i,
	input wire logic standby_low_i,
	// raw pixel samples from converter
	input wire logic [9:0] adc_data_i,
	// pixel stream
	output logic [9:0] pixel_bus_o,
	output logic pixel_clock_out_o,
	output logic line_sync_o,
	output logic frame_sync_o,
	// sync display mode selects
	input wire logic line_valid_mode_i,
	input wire logic frame_valid_mode_i,
	// current scan position for the array
	output logic [9:0] array_col_o,
	output logic [8:0] array_row_o,
	// axi4-lite write address
	input wire logic [5:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [5:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [1:0] chip_reset_low_sync_reg;
	logic [1:0] stby_sync_reg;

	// two stages each; only the second stage is read
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			chip_reset_low_sync_reg <= 2'b00;
			stby_sync_reg <= 2'b00;
		end
		else
		begin
			chip_reset_low_sync_reg <= {chip_reset_low_sync_reg[0], chip_reset_low_i};
			stby_sync_reg <= {stby_sync_reg[0], standby_low_i};
		end
	end

	logic chip_rst;
	logic run;
	assign chip_rst = rst_i || !chip_reset_low_sync_reg[1];
	assign run = stby_sync_reg[1] && !chip_rst;

	// ----------------------------------------
	// register file
	// ----------------------------------------
	logic [7:0] regs_reg [0:`ISR_NUM_REGS-2];
	logic [7:0] rst_val [0:`ISR_NUM_REGS-2];
	assign rst_val[0] = `ISR_RST_MODE;
	assign rst_val[1] = `ISR_RST_ORIENT;
	assign rst_val[2] = `ISR_RST_ROW_HI;
	assign rst_val[3] = `ISR_RST_ROW_LO;
	assign rst_val[4] = `ISR_RST_COL_HI;
	assign rst_val[5] = `ISR_RST_COL_LO;
	assign rst_val[6] = `ISR_RST_RCNT_HI;
	assign rst_val[7] = `ISR_RST_RCNT_LO;
	assign rst_val[8] = `ISR_RST_CCNT_HI;
	assign rst_val[9] = `ISR_RST_CCNT_LO;
	assign rst_val[10] = `ISR_RST_RSVD;

	// write channel capture; address and data taken in either order
	logic aw_hold_reg;
	logic w_hold_reg;
	logic [3:0] aw_idx_reg;
	logic aw_bad_reg;
	logic [7:0] w_byte_reg;
	logic w_en_reg;
	logic do_write;

	assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
	assign s_axi_wready = !w_hold_reg && !s_axi_bvalid;
	assign do_write = aw_hold_reg && w_hold_reg;

	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			aw_hold_reg <= 1'b0;
			w_hold_reg <= 1'b0;
			aw_idx_reg <= 4'h0;
			aw_bad_reg <= 1'b0;
			w_byte_reg <= 8'h00;
			w_en_reg <= 1'b0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_hold_reg <= 1'b1;
				aw_idx_reg <= s_axi_awaddr[5:2];
				aw_bad_reg <= s_axi_awaddr[5:2] > `ISR_IDX_STATUS;
			end
			else if (do_write)
				aw_hold_reg <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_hold_reg <= 1'b1;
				w_byte_reg <= s_axi_wdata[7:0];
				w_en_reg <= s_axi_wstrb[0];
			end
			else if (do_write)
				w_hold_reg <= 1'b0;
		end
	end

	// storage; chip reset pin also restores defaults
	genvar gi;
	generate
		for (gi = 0; gi < `ISR_NUM_REGS - 1; gi++)
		begin : g_reg
			always_ff @(posedge ref_clk_i)
			begin
				if (chip_rst)
					regs_reg[gi] <= rst_val[gi];
				else if (do_write && w_en_reg && aw_idx_reg == 4'(gi) && gi != 10)
					regs_reg[gi] <= w_byte_reg;
			end
		end
	endgenerate

	// write response; unmapped address answers slverr
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
		end
		else if (do_write)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= aw_bad_reg ? 2'b10 : 2'b00;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// read path, one cycle after address accepted
	logic [7:0] status_byte;
	assign s_axi_arready = !s_axi_rvalid;
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'b00;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= 2'b00;
			if (s_axi_araddr[5:2] < `ISR_IDX_STATUS)
				s_axi_rdata <= {24'h00_0000, regs_reg[s_axi_araddr[5:2]]};
			else if (s_axi_araddr[5:2] == `ISR_IDX_STATUS)
				s_axi_rdata <= {24'h00_0000, status_byte};
			else
			begin
				s_axi_rdata <= 32'h0000_0000;
				s_axi_rresp <= 2'b10;
			end
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// ----------------------------------------
	// decoded settings
	// ----------------------------------------
	logic [8:0] row_start;
	logic [8:0] col_start;
	logic [8:0] row_count;
	logic [9:0] col_count;
	assign row_start = {regs_reg[2][0], regs_reg[3]};
	assign col_start = {regs_reg[4][0], regs_reg[5]};
	assign row_count = {regs_reg[6][0], regs_reg[7]};
	assign col_count = {regs_reg[8][1:0], regs_reg[9]};

	logic bad_pix_en;
	logic dark_auto;
	logic ch_sep;
	logic shutter_en;
	logic vmir;
	logic hmir;
	logic [1:0] row_step;
	logic [1:0] col_step;
	assign bad_pix_en = regs_reg[0][`ISR_F_BADPIX];
	assign shutter_en = regs_reg[0][`ISR_F_SHUTTER];
	assign dark_auto = regs_reg[0][`ISR_F_DARKAUTO];
	assign ch_sep = regs_reg[0][`ISR_F_CHSEP];
	assign vmir = regs_reg[1][`ISR_F_VMIRROR];
	assign hmir = regs_reg[1][`ISR_F_HMIRROR];
	assign row_step = regs_reg[1][3:2];
	assign col_step = regs_reg[1][1:0];

	// ----------------------------------------
	// pixel clock
	// ----------------------------------------
	logic tick;
	isr_clk_div u_div (
		.ref_clk_i(ref_clk_i),
		.rst_i(chip_rst),
		.run_i(run),
		.div_sel_i(regs_reg[1][5:4]),
		.tick_o(tick),
		.pclk_o(pixel_clock_out_o)
	);

	// ----------------------------------------
	// readout sequencer
	// ----------------------------------------
	isr_pkg::isr_state_t state_reg;
	logic [9:0] col_reg;
	logic [8:0] row_reg;
	logic [7:0] blank_reg;
	logic [3:0] vblank_reg;
	logic frame_gap;

	// columns and rows advance by subsample code plus one
	always_ff @(posedge ref_clk_i)
	begin
		if (chip_rst || !run)
		begin
			state_reg <= isr_pkg::ISR_IDLE;
			col_reg <= 10'h000;
			row_reg <= 9'h000;
			blank_reg <= 8'h00;
			vblank_reg <= 4'h0;
		end
		else if (tick)
		begin
			unique case (state_reg)
				isr_pkg::ISR_IDLE:
				begin
					state_reg <= isr_pkg::ISR_LINE;
					col_reg <= 10'h000;
					row_reg <= 9'h000;
				end
				isr_pkg::ISR_LINE:
				begin
					if (col_reg + 10'({8'h00, col_step}) + 10'h001 >= col_count)
					begin
						state_reg <= isr_pkg::ISR_BLANK;
						blank_reg <= 8'h00;
						col_reg <= 10'h000;
					end
					else
						col_reg <= col_reg + 10'({8'h00, col_step}) + 10'h001;
				end
				isr_pkg::ISR_BLANK:
				begin
					if (frame_gap)
					begin
						if (blank_reg == `ISR_HBLANK)
						begin
							blank_reg <= 8'h00;
							if (vblank_reg == `ISR_VBLANK)
							begin
								vblank_reg <= 4'h0;
								row_reg <= 9'h000;
								state_reg <= isr_pkg::ISR_LINE;
							end
							else
								vblank_reg <= vblank_reg + 4'h1;
						end
						else
							blank_reg <= blank_reg + 8'h01;
					end
					else if (blank_reg == `ISR_HBLANK)
					begin
						row_reg <= row_reg + 9'({7'h00, row_step}) + 9'h001;
						state_reg <= isr_pkg::ISR_LINE;
					end
					else
						blank_reg <= blank_reg + 8'h01;
				end
				default: state_reg <= isr_pkg::ISR_IDLE;
			endcase
		end
	end
	assign frame_gap = row_reg + 9'({7'h00, row_step}) + 9'h001 >= row_count;

	// array address with window offset and mirroring
	always_ff @(posedge ref_clk_i)
	begin
		if (chip_rst)
		begin
			array_col_o <= 10'h000;
			array_row_o <= 9'h000;
		end
		else
		begin
			array_col_o <= hmir ? 10'({1'b0, col_start}) + col_count - 10'h001 - col_reg
				: 10'({1'b0, col_start}) + col_reg;
			array_row_o <= vmir ? row_start + row_count - 9'h001 - row_reg
				: row_start + row_reg;
		end
	end

	// ----------------------------------------
	// pixel processing and output
	// ----------------------------------------
	logic [9:0] res_mask;
	logic [9:0] prev_pix_reg;
	logic [9:0] pix;
	logic in_line;
	assign in_line = state_reg == isr_pkg::ISR_LINE;
	always_comb
	begin
		unique case (regs_reg[0][1:0])
			2'b00: res_mask = 10'h3fc;
			2'b01: res_mask = 10'h3fe;
			default: res_mask = 10'h3ff;
		endcase
	end

	// stuck full-scale or zero sample treated as defective: reuse previous
	// limitation: no threshold or neighbour filter, kept small on purpose
	always_comb
	begin
		pix = adc_data_i;
		if (bad_pix_en && (adc_data_i == 10'h3ff || adc_data_i == 10'h000))
			pix = prev_pix_reg;
	end

	// output registers update on pixel tick only, stable over a pixel clock except at divide by one, where they change every ref clock
	always_ff @(posedge ref_clk_i)
	begin
		if (chip_rst)
		begin
			pixel_bus_o <= 10'h000;
			prev_pix_reg <= 10'h000;
			line_sync_o <= 1'b0;
			frame_sync_o <= 1'b0;
		end
		else if (tick)
		begin
			pixel_bus_o <= in_line ? (pix & res_mask) : 10'h000;
			if (in_line)
				prev_pix_reg <= pix;
			// valid mode marks active pixels, sync mode pulses at line end as blanking begins
			line_sync_o <= line_valid_mode_i ? in_line
				: (state_reg == isr_pkg::ISR_BLANK && blank_reg == 8'h00);
			// last row still counts as a frame row; only the gap drops valid
			frame_sync_o <= frame_valid_mode_i
				? (in_line || (state_reg == isr_pkg::ISR_BLANK && !frame_gap))
				: (frame_gap && vblank_reg == 4'h0 && state_reg == isr_pkg::ISR_BLANK);
		end
	end

	// status: mode echoes and live sequencer state
	assign status_byte = {2'b00, dark_auto, ch_sep, shutter_en, in_line, frame_gap, run};

	// ----------------------------------------
	// checks
	// ----------------------------------------
	reset_mode_a: assert property (@(posedge ref_clk_i) chip_rst |=> regs_reg[0] == `ISR_RST_MODE)
		else $error("mode register not at default after reset");
	standby_idle_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!run |=> state_reg == isr_pkg::ISR_IDLE && !pixel_clock_out_o)
		else $error("readout active in standby");
	low_bits_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(regs_reg[0][1:0] == 2'b00 && tick) |=> pixel_bus_o[1:0] == 2'b00)
		else $error("unused low bits set at 8-bit");
	// a divider change mid-count restarts the spacing, so the code must stand
	div_two_a: assert property (@(posedge ref_clk_i) disable iff (chip_rst)
		(run && regs_reg[1][5:4] == 2'b01 && tick) ##1 (run && regs_reg[1][5:4] == 2'b01)[*2]
		|-> tick && !$past(tick))
		else $error("divide by two tick spacing wrong");
	line_valid_a: assert property (@(posedge ref_clk_i) disable iff (chip_rst)
		(tick && line_valid_mode_i) |=> line_sync_o == $past(in_line))
		else $error("line valid not tracking active pixels");
	row_start_a: assert property (@(posedge ref_clk_i) disable iff (chip_rst)
		!vmir |=> array_row_o == $past(row_start) + $past(row_reg))
		else $error("row address ignores window start");
	res_mask_a: assert property (@(posedge ref_clk_i) disable iff (chip_rst)
		(regs_reg[0][1:0] == 2'b01 && tick) |=> pixel_bus_o[0] == 1'b0)
		else $error("nine bit mask wrong");
	bus_idle_a: assert property (@(posedge ref_clk_i) disable iff (chip_rst)
		(tick && !in_line) |=> pixel_bus_o == 10'h000)
		else $error("pixel bus not zero outside line");
endmodule : isr_readout

// ==== isr_params.svh ====
// constants and register map for the image sensor readout control block
`ifndef ISR_PARAMS_SVH
`define ISR_PARAMS_SVH
// ----------------------------------------
// register indices (byte address is index times four)
// ----------------------------------------
`define ISR_IDX_MODE 4'h0
`define ISR_IDX_ORIENT 4'h1
`define ISR_IDX_ROW_HI 4'h2
`define ISR_IDX_ROW_LO 4'h3
`define ISR_IDX_COL_HI 4'h4
`define ISR_IDX_COL_LO 4'h5
`define ISR_IDX_RCNT_HI 4'h6
`define ISR_IDX_RCNT_LO 4'h7
`define ISR_IDX_CCNT_HI 4'h8
`define ISR_IDX_CCNT_LO 4'h9
`define ISR_IDX_RSVD 4'ha
`define ISR_IDX_STATUS 4'hb
`define ISR_NUM_REGS 12
// ----------------------------------------
// reset values
// ----------------------------------------
`define ISR_RST_MODE 8'h02
`define ISR_RST_ORIENT 8'h10
`define ISR_RST_ROW_HI 8'h00
`define ISR_RST_ROW_LO 8'h0e
`define ISR_RST_COL_HI 8'h00
`define ISR_RST_COL_LO 8'h0e
`define ISR_RST_RCNT_HI 8'h01
`define ISR_RST_RCNT_LO 8'he0
`define ISR_RST_CCNT_HI 8'h02
`define ISR_RST_CCNT_LO 8'h80
`define ISR_RST_RSVD 8'h80
// ----------------------------------------
// field positions
// ----------------------------------------
`define ISR_F_BADPIX 5
`define ISR_F_DARKAUTO 4
`define ISR_F_CHSEP 3
`define ISR_F_SHUTTER 2
`define ISR_F_VMIRROR 7
`define ISR_F_HMIRROR 6
// ----------------------------------------
// timing counts (HBLANK in pixel clocks, VBLANK in blank line periods)
// ----------------------------------------
`define ISR_HBLANK 8'h20
`define ISR_VBLANK 4'h4
`endif

// ==== isr_pkg.sv ====
// types for the image sensor readout control block
package isr_pkg;
	// readout sequencer states, one-hot
	typedef enum logic [2:0] {
		ISR_IDLE = 3'b001,
		ISR_LINE = 3'b010,
		ISR_BLANK = 3'b100
	} isr_state_t;
endpackage : isr_pkg

// ==== isr_clk_div.sv ====
// pixel clock divider giving a one-cycle enable and a clock level
`timescale 1ns/100ps
module isr_clk_div (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// control
	input wire logic run_i,
	input wire logic [1:0] div_sel_i,
	// outputs
	output logic tick_o,
	output logic pclk_o
);
	logic [2:0] cnt_reg;
	logic [2:0] top;
	logic pclk_reg;

	// terminal count from divider code; divide by 2^code
	always_comb
	begin
		unique case (div_sel_i)
			2'b00: top = 3'h0;
			2'b01: top = 3'h1;
			2'b10: top = 3'h3;
			2'b11: top = 3'h7;
		endcase
	end

	// free counter, cleared while stopped
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i || !run_i || cnt_reg >= top)
			cnt_reg <= 3'h0;
		else
			cnt_reg <= cnt_reg + 3'h1;
	end

	assign tick_o = run_i && (cnt_reg == top);

	// clock falls as the outputs change and rises mid-pixel, so the receiver
	// never samples on the edge that launches data; divide by one only toggles
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i || !run_i)
			pclk_reg <= 1'b0;
		else if (top == 3'h0)
			pclk_reg <= ~pclk_reg;
		else
			pclk_reg <= (cnt_reg >= (top >> 1)) && (cnt_reg != top);
	end
	assign pclk_o = pclk_reg;
endmodule : isr_clk_div

// ==== isr_pixel_sink.sv ====
// receiving-side model of the pixel stream: counts pixels per line
`timescale 1ns/100ps
module isr_pixel_sink (
	// stream from the readout block
	input wire logic pclk_i,
	input wire logic line_sync_i,
	input wire logic [9:0] pixel_bus_i,
	// observations for the bench
	output logic [15:0] line_len_o,
	output logic [9:0] last_pixel_o
);
	// ----------------------------------------
	// capture state
	// ----------------------------------------
	logic [15:0] cnt_reg = 16'h0000;
	logic in_line_reg = 1'b0;
	initial line_len_o = 16'h0000;
	initial last_pixel_o = 10'h000;
	// sample bus and sync only on the rising pixel clock, as a receiver would
	always @(posedge pclk_i)
	begin
		in_line_reg <= line_sync_i;
		if (line_sync_i === 1'b1)
		begin
			cnt_reg <= cnt_reg + 16'h0001;
			last_pixel_o <= pixel_bus_i;
		end
		else if (in_line_reg)
		begin
			line_len_o <= cnt_reg;
			cnt_reg <= 16'h0000;
		end
	end
endmodule : isr_pixel_sink

// ==== image_sensor_readout_control_bench.sv ====
// self-checking bench for the image sensor readout block
`timescale 1ns/100ps
module image_sensor_readout_control_bench;
	// ----------------------------------------
	// stimulus and observed signals
	// ----------------------------------------
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic chip_reset_low_i = 1'b1;
	logic standby_low_i = 1'b0; // held in standby while the window is set up
	logic [9:0] adc_data_i = 10'h2a7;
	logic line_valid_mode_i = 1'b1;
	logic frame_valid_mode_i = 1'b1;
	logic [5:0] awaddr = 6'h00;
	logic [5:0] araddr = 6'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [9:0] pixel_bus, array_col;
	logic [8:0] array_row;
	logic pclk, line_sync, frame_sync, awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [15:0] sink_len;
	int mismatches = 0;
	int compares = 0;
	logic [7:0] rst_tab [11] = '{8'h02, 8'h10, 8'h00, 8'h0e, 8'h00, 8'h0e, 8'h01, 8'he0,
		8'h02, 8'h80, 8'h80};
	logic [9:0] res_tab [3] = '{10'h2a4, 10'h2a6, 10'h2a7};
	// 40 ns clock
	initial
	begin
		forever #20 ref_clk_i = ~ref_clk_i;
	end
	isr_readout dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .chip_reset_low_i(chip_reset_low_i),
		.standby_low_i(standby_low_i), .adc_data_i(adc_data_i), .pixel_bus_o(pixel_bus),
		.pixel_clock_out_o(pclk), .line_sync_o(line_sync), .frame_sync_o(frame_sync),
		.line_valid_mode_i(line_valid_mode_i), .frame_valid_mode_i(frame_valid_mode_i),
		.array_col_o(array_col), .array_row_o(array_row), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	isr_pixel_sink sink (.pclk_i(pclk), .line_sync_i(line_sync), .pixel_bus_i(pixel_bus),
		.line_len_o(sink_len), .last_pixel_o());
	// ----------------------------------------
	// compare, bus and wait helpers
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		compares++;
		if (got !== exp)
		begin
			mismatches++;
			$display("MISMATCH at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask : chk
	// write one register; aw and w offered together, each dropped once taken
	task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic [1:0] er);
		logic done;
		@(posedge ref_clk_i);
		awaddr <= a;
		wdata <= {24'h00_0000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		done = 1'b0;
		for (int n = 0; n < 50 && !done; n++)
		begin
			@(posedge ref_clk_i);
			if (awready === 1'b1)
				awvalid <= 1'b0;
			if (wready === 1'b1)
				wvalid <= 1'b0;
			if (bvalid === 1'b1)
			begin
				bready <= 1'b0;
				done = 1'b1;
				chk(32'(bresp), 32'(er), "write response");
			end
		end
		if (!done)
			chk(32'h0, 32'h1, "write timeout");
	endtask : wr
	// read one register and compare the masked data
	task automatic rd(input logic [5:0] a, input logic [7:0] e, input logic [1:0] er,
		input logic [31:0] m = 32'hffff_ffff);
		logic done;
		@(posedge ref_clk_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		done = 1'b0;
		for (int n = 0; n < 50 && !done; n++)
		begin
			@(posedge ref_clk_i);
			if (arready === 1'b1)
				arvalid <= 1'b0;
			if (rvalid === 1'b1)
			begin
				rready <= 1'b0;
				done = 1'b1;
				chk(32'(rresp), 32'(er), "read response");
				chk(rdata & m, {24'h00_0000, e}, "read data");
			end
		end
		if (!done)
			chk(32'h0, 32'h1, "read timeout");
	endtask : rd
	function automatic logic sig(input int s);
		return s == 0 ? line_sync : (s == 1 ? frame_sync : pclk);
	endfunction : sig
	// bounded wait for a rising edge of line sync, frame sync or pixel clock
	task automatic rise(input int s);
		int n;
		n = 0;
		while (sig(s) !== 1'b0 && n < 5000)
		begin
			@(posedge ref_clk_i);
			n++;
		end
		while (sig(s) !== 1'b1 && n < 5000)
		begin
			@(posedge ref_clk_i);
			n++;
		end
		if (n >= 5000)
			chk(32'h0, 32'h1, "wait timeout");
	endtask : rise
	// high time of the next pulse, in reference clocks
	task automatic width(input int s, output int w);
		rise(s);
		w = 0;
		while (sig(s) === 1'b1 && w < 5000)
		begin
			@(posedge ref_clk_i);
			w++;
		end
	endtask : width
	task automatic print_verdict();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : print_verdict
	// ----------------------------------------
	// test sequence
	// ----------------------------------------
	initial
	begin
		int w, n, k;
		logic lprev;
		logic [8:0] row;
		logic [9:0] col;
		repeat (20) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		foreach (rst_tab[i]) rd(6'(i * 4), rst_tab[i], 2'b00);
		wr(6'h28, 8'h55, 2'b00);
		rd(6'h28, 8'h80, 2'b00);
		wr(6'h30, 8'h11, 2'b10);
		rd(6'h30, 8'h00, 2'b10);
		wr(6'h04, 8'hdb, 2'b00);
		rd(6'h04, 8'hdb, 2'b00);
		wr(6'h04, 8'h10, 2'b00);
		$display("test registers done");
		// window 4 rows of 16 pixels, first row 261 across the split pair
		wr(6'h08, 8'h01, 2'b00);
		wr(6'h0c, 8'h05, 2'b00);
		wr(6'h18, 8'h00, 2'b00);
		wr(6'h1c, 8'h04, 2'b00);
		wr(6'h20, 8'h00, 2'b00);
		wr(6'h24, 8'h10, 2'b00);
		n = 0;
		repeat (200)
		begin
			@(posedge ref_clk_i);
			n += (pclk !== 1'b0 || line_sync !== 1'b0) ? 1 : 0;
		end
		chk(32'(n), 32'h0, "standby activity");
		standby_low_i <= 1'b1;
		for (int c = 0; c < 4; c++)
		begin
			wr(6'h04, 8'(c << 4), 2'b00);
			rise(0);
			width(0, w);
			chk(32'(w), 32'(16 << c), "line width");
			rise(2);
			rise(2);
			if (c > 0)
				chk(32'(sink_len), 32'h10, "pixels per line");
		end
		$display("test divider done");
		for (int m = 0; m < 2; m++)
		begin
			wr(6'h04, m ? 8'hd0 : 8'h10, 2'b00);
			rise(1);
			rise(1);
			n = 0;
			k = 0;
			lprev = 1'b0;
			while (frame_sync === 1'b1 && k < 5000)
			begin
				if (line_sync === 1'b1 && !lprev)
				begin
					if (n == 0)
					begin
						row = array_row;
						col = array_col;
					end
					n++;
				end
				lprev = line_sync;
				@(posedge ref_clk_i);
				k++;
			end
			chk(32'(n), 32'h4, "rows per frame");
			chk(32'(row), m ? 32'd264 : 32'd261, "first row");
			chk(32'(col), m ? 32'd29 : 32'd14, "first column");
		end
		$display("test frame done");
		line_valid_mode_i <= 1'b0;
		frame_valid_mode_i <= 1'b0;
		width(0, w);
		chk(32'(w), 32'h2, "line pulse");
		width(1, w);
		chk(32'(w > 0 && w < 96), 32'h1, "frame pulse");
		line_valid_mode_i <= 1'b1;
		frame_valid_mode_i <= 1'b1;
		for (int r = 0; r < 3; r++)
		begin
			wr(6'h00, 8'(r), 2'b00);
			rise(0);
			rise(2);
			rise(2);
			chk(32'(pixel_bus), 32'(res_tab[r]), "masked pixel");
		end
		wr(6'h00, 8'h3a, 2'b00);
		rd(6'h2c, 8'h30, 2'b00, 32'h0000_0038);
		wr(6'h00, 8'h26, 2'b00);
		rd(6'h2c, 8'h08, 2'b00, 32'h0000_0038);
		rise(0);
		adc_data_i <= 10'h3ff;
		rise(0);
		rise(2);
		chk(32'(pixel_bus), 32'h0000_02a7, "bad pixel kept");
		wr(6'h00, 8'h02, 2'b00);
		rise(0);
		rise(2);
		chk(32'(pixel_bus), 32'h0000_03ff, "bad pixel passed");
		$display("test pixel modes done");
		chip_reset_low_i <= 1'b0;
		repeat (5) @(posedge ref_clk_i);
		chip_reset_low_i <= 1'b1;
		repeat (6) @(posedge ref_clk_i);
		rd(6'h24, 8'h80, 2'b00);
		rd(6'h0c, 8'h0e, 2'b00);
		$display("test chip reset done");
		print_verdict();
	end
	// hang guard, well beyond the expected run length
	initial
	begin
		#(1_600_000);
		mismatches++;
		print_verdict();
	end
endmodule : image_sensor_readout_control_bench
